// ---- threshold_irq_enable_cfg_params.svh ----
// offsets, field positions, reset values and selector codes of the threshold interrupt block
`ifndef THRESHOLD_IRQ_ENABLE_CFG_PARAMS_SVH
`define THRESHOLD_IRQ_ENABLE_CFG_PARAMS_SVH

// printed register indices; byte address is four times the index
`define EN_CFG_INDEX      8'h28
`define THR89_INDEX       8'h2d
`define EN_CFG_ADDR       8'ha0
`define THR89_ADDR        8'hb4
// status, mask and relation registers
`define IRQ_STAT_ADDR     8'hc0
`define IRQ_MASK_ADDR     8'hc4
`define RELATION_ADDR     8'hc8

// reset values
`define EN_CFG_RESET      24'h000000
`define THR89_RESET       20'h00000
`define IRQ_STAT_RESET    12'h000
`define IRQ_MASK_RESET    12'h000

// selector field positions inside the enable register
`define SW22_SEL_LSB      0
`define SW23_SEL_LSB      6
`define SUPPLY_A_SEL_LSB  16
`define SUPPLY_B_SEL_LSB  20

// threshold field positions inside the threshold 8/9 register
`define THR8_LSB          0
`define THR9_LSB          10

// 2-bit edge selector codes
`define SEL_NONE          2'h0
`define SEL_RISE          2'h1
`define SEL_FALL          2'h2
`define SEL_BOTH          2'h3

// number of input/threshold pairings watched
`define NUM_CHAN          12

`endif

// ---- threshold_irq_pkg.sv ----
// types shared by the threshold interrupt block and its crossing detector
`default_nettype none
package threshold_irq_pkg;

    // classic wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    // threshold values supplied from outside the block
    typedef struct packed {
        logic [9:0] multi_level_threshold_a;
        logic [9:0] multi_level_threshold_b;
        logic [9:0] multi_level_threshold_c;
        logic [9:0] supply_first_threshold_a;
        logic [9:0] supply_first_threshold_b;
        logic [9:0] supply_second_threshold_a;
        logic [9:0] supply_second_threshold_b;
    } thr_set_t;

    // converted samples, each with its valid strobe
    typedef struct packed {
        logic [9:0] supply_sample;
        logic       supply_valid;
        logic [9:0] switch_input_twentytwo;
        logic       twentytwo_valid;
        logic [9:0] switch_input_twentythree;
        logic       twentythree_valid;
    } sample_set_t;

    // bus answer state
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

    // state of one crossing detector
    typedef struct packed {
        logic primed;
        logic above;
        logic evt;
    } det_state_t;

    // state of the register block
    typedef struct packed {
        logic [23:0] en_cfg;
        logic [19:0] thr89;
        logic [11:0] status;
        logic [11:0] mask;
        bus_state_t  bus;
        logic [31:0] rdata;
    } main_state_t;

endpackage
`default_nettype wire

// ---- crossing_detect.sv ----
// crossing detector for one input/threshold pairing with edge selection
`include "threshold_irq_enable_cfg_params.svh"
`default_nettype none
module crossing_detect (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // sample and threshold
    input  wire logic [9:0] sample_i,
    input  wire logic       valid_i,
    input  wire logic [9:0] threshold_i,
    // edge selector
    input  wire logic [1:0] select_i,
    // results
    output logic            evt_o,
    output logic            above_o
);
    import threshold_irq_pkg::*;

    det_state_t st_r;    // registered state
    det_state_t st_nxt;  // next state
    logic       gt;      // new sample above threshold
    logic       rise;    // below to above
    logic       fall;    // above to below

    // relation of each sample is kept; the first one after reset only primes it
    always_comb begin
        st_nxt = st_r;
        st_nxt.evt = 1'b0;
        gt = sample_i > threshold_i;
        rise = !st_r.above && gt;
        fall = st_r.above && !gt;
        if (valid_i) begin
            st_nxt.primed = 1'b1;
            st_nxt.above = gt;
            if (st_r.primed) begin
                unique case (select_i)
                    `SEL_NONE: st_nxt.evt = 1'b0;
                    `SEL_RISE: st_nxt.evt = rise;
                    `SEL_FALL: st_nxt.evt = fall;
                    `SEL_BOTH: st_nxt.evt = rise || fall;
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign evt_o = st_r.evt;
    assign above_o = st_r.above;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_none_quiet: assert property (select_i == `SEL_NONE |=> !evt_o)
        else $error("event with selector off");
    a_rise_fires: assert property (valid_i && st_r.primed && rise && select_i == `SEL_RISE |=> evt_o)
        else $error("rising crossing missed");
    a_fall_fires: assert property (valid_i && st_r.primed && fall && select_i == `SEL_FALL |=> evt_o)
        else $error("falling crossing missed");
    a_both_fires: assert property (valid_i && st_r.primed && (rise || fall) && select_i == `SEL_BOTH |=> evt_o)
        else $error("crossing missed in both mode");
    a_no_cross: assert property (!(valid_i && st_r.primed && (rise || fall)) |=> !evt_o)
        else $error("event without crossing");
endmodule
`default_nettype wire

// ---- threshold_irq_enable_cfg.sv ----
// threshold crossing interrupt enables for the supply input and switch inputs 22 and 23
//
// How it works
// - selector 00 gives no interrupt
// - selector 01 interrupts on upward crossing
// - selector 10 interrupts on downward crossing
// - selector 11 interrupts on both crossings
// - bits 23-20 select supply second set
// - bits 19-16 select supply first set
// - bits 15-6 input 23, pairs 3A-3C
// - fourth input 23 pair selects threshold eight
// - top input 23 pair selects threshold nine
// - bits 5-0 input 22, pairs 3A-3C
// - thresholds eight and nine software programmable
`include "threshold_irq_enable_cfg_params.svh"
`default_nettype none
module threshold_irq_enable_cfg (
    // clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    // wishbone slave
    input  wire threshold_irq_pkg::wb_req_t     wb_req_i,
    output logic                                wb_ack_o,
    output logic [31:0]                         wb_dat_o,
    // threshold values
    input  wire threshold_irq_pkg::thr_set_t    thr_i,
    // converted samples
    input  wire threshold_irq_pkg::sample_set_t smp_i,
    // interrupt
    output logic                                irq_o
);
    import threshold_irq_pkg::*;

    ////////////////////////////////////////////////////////////////
    // helpers
    ////////////////////////////////////////////////////////////////

    // word address match; byte lanes within the word are ignored
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] b);
        return a[7:2] == b[7:2];
    endfunction

    // byte lane mask from wishbone select
    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // merge write data into an old word lane by lane
    // lanes that sel leaves out keep their old contents
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] din,
                                          input logic [3:0]  sel);
        return (old & ~byte_mask(sel)) | (din & byte_mask(sel));
    endfunction

    ////////////////////////////////////////////////////////////////
    // declarations
    ////////////////////////////////////////////////////////////////

    main_state_t st_r;                       // registered state
    main_state_t st_nxt;                     // next state
    logic [9:0]  ch_smp [`NUM_CHAN];         // sample per channel
    logic        ch_vld [`NUM_CHAN];         // valid per channel
    logic [9:0]  ch_thr [`NUM_CHAN];         // threshold per channel
    logic [11:0] ch_evt;                     // crossing pulses
    logic [11:0] ch_above;                   // current relations
    logic [11:0] clr;                        // write-one-to-clear bits
    logic        req;                        // request present
    logic        wr;                         // write completes this edge
    logic [31:0] rd_mux;                     // read data selection
    logic [31:0] wmerge;                     // merged write word

    ////////////////////////////////////////////////////////////////
    // channel routing
    ////////////////////////////////////////////////////////////////

    // channel i uses selector bits [2i+1:2i] of the enable register,
    // so the status and mask bit i line up with selector pair i
    // and the relation bit i as well
    always_comb begin
        // input 22 against the multi-level set
        ch_smp[0] = smp_i.switch_input_twentytwo;
        ch_smp[1] = smp_i.switch_input_twentytwo;
        ch_smp[2] = smp_i.switch_input_twentytwo;
        ch_vld[0] = smp_i.twentytwo_valid;
        ch_vld[1] = smp_i.twentytwo_valid;
        ch_vld[2] = smp_i.twentytwo_valid;
        ch_thr[0] = thr_i.multi_level_threshold_a;
        ch_thr[1] = thr_i.multi_level_threshold_b;
        ch_thr[2] = thr_i.multi_level_threshold_c;
        // input 23 against the multi-level set
        ch_smp[3] = smp_i.switch_input_twentythree;
        ch_smp[4] = smp_i.switch_input_twentythree;
        ch_smp[5] = smp_i.switch_input_twentythree;
        ch_vld[3] = smp_i.twentythree_valid;
        ch_vld[4] = smp_i.twentythree_valid;
        ch_vld[5] = smp_i.twentythree_valid;
        ch_thr[3] = thr_i.multi_level_threshold_a;
        ch_thr[4] = thr_i.multi_level_threshold_b;
        ch_thr[5] = thr_i.multi_level_threshold_c;
        // input 23 against thresholds eight and nine
        // eight and nine live in this block; other levels come in as ports
        ch_smp[6] = smp_i.switch_input_twentythree;
        ch_smp[7] = smp_i.switch_input_twentythree;
        ch_vld[6] = smp_i.twentythree_valid;
        ch_vld[7] = smp_i.twentythree_valid;
        ch_thr[6] = st_r.thr89[`THR8_LSB +: 10];
        ch_thr[7] = st_r.thr89[`THR9_LSB +: 10];
        // supply against the first set
        ch_smp[8] = smp_i.supply_sample;
        ch_smp[9] = smp_i.supply_sample;
        ch_vld[8] = smp_i.supply_valid;
        ch_vld[9] = smp_i.supply_valid;
        ch_thr[8] = thr_i.supply_first_threshold_a;
        ch_thr[9] = thr_i.supply_first_threshold_b;
        // supply against the second set
        ch_smp[10] = smp_i.supply_sample;
        ch_smp[11] = smp_i.supply_sample;
        ch_vld[10] = smp_i.supply_valid;
        ch_vld[11] = smp_i.supply_valid;
        ch_thr[10] = thr_i.supply_second_threshold_a;
        ch_thr[11] = thr_i.supply_second_threshold_b;
    end

    ////////////////////////////////////////////////////////////////
    // crossing detectors
    ////////////////////////////////////////////////////////////////

    // one detector per pairing; a selector change acts on the next sample
    // relations are tracked even under selector 00, so enabling a pair
    // later cannot fire on a stale relation
    for (genvar i = 0; i < `NUM_CHAN; i++) begin : g_det
        crossing_detect u_det (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .sample_i    (ch_smp[i]),
            .valid_i     (ch_vld[i]),
            .threshold_i (ch_thr[i]),
            .select_i    (st_r.en_cfg[2*i +: 2]),
            .evt_o       (ch_evt[i]),
            .above_o     (ch_above[i])
        );
    end

    ////////////////////////////////////////////////////////////////
    // read multiplexer
    ////////////////////////////////////////////////////////////////

    // unmapped words read as zero, reserved bits as zero
    // the word is captured as the request is taken, a cycle before ack
    always_comb begin
        rd_mux = 32'h00000000;
        if (addr_hit(wb_req_i.adr, `EN_CFG_ADDR)) begin
            rd_mux = {8'h00, st_r.en_cfg};
        end else if (addr_hit(wb_req_i.adr, `THR89_ADDR)) begin
            rd_mux = {12'h000, st_r.thr89};
        end else if (addr_hit(wb_req_i.adr, `IRQ_STAT_ADDR)) begin
            rd_mux = {20'h00000, st_r.status};
        end else if (addr_hit(wb_req_i.adr, `IRQ_MASK_ADDR)) begin
            rd_mux = {20'h00000, st_r.mask};
        end else if (addr_hit(wb_req_i.adr, `RELATION_ADDR)) begin
            rd_mux = {20'h00000, ch_above};
        end
    end

    ////////////////////////////////////////////////////////////////
    // next state
    ////////////////////////////////////////////////////////////////

    // ack follows one cycle after the request is seen; the write lands on
    // the same edge at which the master samples ack, never earlier
    always_comb begin
        st_nxt = st_r;
        clr = 12'h000;
        req = wb_req_i.cyc && wb_req_i.stb;
        wr = (st_r.bus == BUS_ACK) && req && wb_req_i.we;
        wmerge = 32'h00000000;
        // bus answer
        unique case (st_r.bus)
            BUS_IDLE: begin
                if (req) begin
                    st_nxt.bus = BUS_ACK;
                    // the captured word stands through the ack cycle
                    st_nxt.rdata = rd_mux;
                end
            end
            BUS_ACK: begin
                // master must release after ack, so go idle
                // a stb still high next cycle is taken as a new request
                st_nxt.bus = BUS_IDLE;
            end
        endcase
        // register writes, lane by lane
        if (wr) begin
            if (addr_hit(wb_req_i.adr, `EN_CFG_ADDR)) begin
                wmerge = merge({8'h00, st_r.en_cfg}, wb_req_i.dat, wb_req_i.sel);
                st_nxt.en_cfg = wmerge[23:0];
            end else if (addr_hit(wb_req_i.adr, `THR89_ADDR)) begin
                wmerge = merge({12'h000, st_r.thr89}, wb_req_i.dat, wb_req_i.sel);
                st_nxt.thr89 = wmerge[19:0];
            end else if (addr_hit(wb_req_i.adr, `IRQ_MASK_ADDR)) begin
                wmerge = merge({20'h00000, st_r.mask}, wb_req_i.dat, wb_req_i.sel);
                st_nxt.mask = wmerge[11:0];
            end else if (addr_hit(wb_req_i.adr, `IRQ_STAT_ADDR)) begin
                wmerge = wb_req_i.dat & byte_mask(wb_req_i.sel);
                clr = wmerge[11:0];
            end
        end
        // sticky status; a crossing in the clearing cycle wins
        // so clearing old bits never loses a fresh crossing
        st_nxt.status = (st_r.status & ~clr) | ch_evt;
    end

    ////////////////////////////////////////////////////////////////
    // state register
    ////////////////////////////////////////////////////////////////

    // every field has a constant reset value
    // the bus state resets idle, so no stale ack follows reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.en_cfg <= `EN_CFG_RESET;
            st_r.thr89 <= `THR89_RESET;
            st_r.status <= `IRQ_STAT_RESET;
            st_r.mask <= `IRQ_MASK_RESET;
            st_r.bus <= BUS_IDLE;
            st_r.rdata <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    ////////////////////////////////////////////////////////////////

    // ack straight from the answer state, data from its register
    assign wb_ack_o = (st_r.bus == BUS_ACK);
    assign wb_dat_o = st_r.rdata;
    // level interrupt while any unmasked status bit is set
    // it falls on the edge at which a clearing write lands
    assign irq_o = |(st_r.status & st_r.mask);

    ////////////////////////////////////////////////////////////////
    // assertions
    ////////////////////////////////////////////////////////////////

    // slave-side view of the bus, the fields and the status bits
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // full-word write to a register, completing at ack
    sequence s_wr_full(logic [7:0] a);
        wb_ack_o && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we &&
        addr_hit(wb_req_i.adr, a) && wb_req_i.sel == 4'hf;
    endsequence

    // new threshold eight/nine reach the detectors after the write
    property p_thr_update;
        logic [31:0] d;
        (s_wr_full(`THR89_ADDR), d = wb_req_i.dat) |=>
            ch_thr[6] == d[9:0] && ch_thr[7] == d[19:10];
    endproperty

    a_thr_write: assert property (p_thr_update)
        else $error("threshold eight/nine not updated");

    // written selector pairs land in the right fields
    property p_cfg_update;
        logic [31:0] d;
        (s_wr_full(`EN_CFG_ADDR), d = wb_req_i.dat) |=> st_r.en_cfg == d[23:0];
    endproperty

    a_cfg_write: assert property (p_cfg_update)
        else $error("enable register not updated");

    // mask writes land whole
    property p_mask_update;
        logic [31:0] d;
        (s_wr_full(`IRQ_MASK_ADDR), d = wb_req_i.dat) |=> st_r.mask == d[11:0];
    endproperty

    a_mask_write: assert property (p_mask_update)
        else $error("mask register not updated");

    // a clear drops every written bit that no new crossing sets again
    property p_clear;
        logic [31:0] d;
        (s_wr_full(`IRQ_STAT_ADDR), d = wb_req_i.dat) |=>
            (st_r.status & d[11:0] & ~$past(ch_evt)) == 12'h000;
    endproperty

    a_stat_clear: assert property (p_clear)
        else $error("status bit survived its clear");

    // a status bit may rise only if its pair was enabled two edges before
    a_supply_b_map: assert property ($rose(st_r.status[10]) |-> $past(st_r.en_cfg[21:20], 2) != `SEL_NONE)
        else $error("second set status without enable");
    a_supply_a_map: assert property ($rose(st_r.status[8]) |-> $past(st_r.en_cfg[17:16], 2) != `SEL_NONE)
        else $error("first set status without enable");
    a_thr8_map: assert property ($rose(st_r.status[6]) |-> $past(st_r.en_cfg[13:12], 2) != `SEL_NONE)
        else $error("threshold eight status without enable");
    a_thr9_map: assert property ($rose(st_r.status[7]) |-> $past(st_r.en_cfg[15:14], 2) != `SEL_NONE)
        else $error("threshold nine status without enable");
    a_twentytwo_map: assert property ($rose(st_r.status[0]) |-> $past(st_r.en_cfg[1:0], 2) != `SEL_NONE)
        else $error("input 22 status without enable");
    a_twentythree_map: assert property ($rose(st_r.status[3]) |-> $past(st_r.en_cfg[7:6], 2) != `SEL_NONE)
        else $error("input 23 status without enable");
    a_second_b_map: assert property ($rose(st_r.status[11]) |-> $past(st_r.en_cfg[23:22], 2) != `SEL_NONE)
        else $error("second set b status without enable");

    // set wins over a clear in the same cycle
    a_set_wins: assert property (ch_evt != 12'h000 |=> (st_r.status & $past(ch_evt)) == $past(ch_evt))
        else $error("crossing lost against clear");

    // ack is a single-cycle answer
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // an idle slave answers every request in the next cycle
    a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request left unanswered");

    // read data stand still between answers
    a_rdata_hold: assert property (!req && !wb_ack_o |=> $stable(wb_dat_o))
        else $error("read data moved while idle");

    // status bits fall only through a write-one-to-clear;
    // any other cycle keeps every bit that was set
    a_status_sticky: assert property (!(wr && addr_hit(wb_req_i.adr, `IRQ_STAT_ADDR))
        |=> (st_r.status & $past(st_r.status)) == $past(st_r.status))
        else $error("status bit lost without a clear");

    // read answers carry the word as it stood when the request was taken,
    // one edge before ack
    a_thr_read: assert property (wb_ack_o && !wb_req_i.we && addr_hit(wb_req_i.adr, `THR89_ADDR)
        |-> wb_dat_o == {12'h000, $past(st_r.thr89)})
        else $error("threshold read data wrong");
    a_relation_read: assert property (wb_ack_o && !wb_req_i.we && addr_hit(wb_req_i.adr, `RELATION_ADDR)
        |-> wb_dat_o == {20'h00000, $past(ch_above)})
        else $error("relation read data wrong");
endmodule
`default_nettype wire

// ---- host_model.sv ----
// host software model: classic wishbone master issuing single register cycles
`default_nettype none
module host_model
    import threshold_irq_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // wishbone master side
    output threshold_irq_pkg::wb_req_t wb_req_o,
    input  wire logic        wb_ack_i,
    input  wire logic [31:0] wb_dat_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idle from time zero, so nothing is taken during reset
    initial wb_req_o = '0;

    ////////////////////////////////////////////////////////////////////////////
    // one classic cycle: request held until ack is sampled, then released
    task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q, output bit ok);
        ok = 1'b0;
        q  = '0;
        @(posedge clk_i);
        wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
        // bounded wait; a missing ack is reported through ok
        for (int i = 0; i < 50 && !ok; i++) begin
            @(posedge clk_i);
            if (wb_ack_i === 1'b1) begin
                ok = 1'b1;
                q  = wb_dat_i;
            end
        end
        // release at the ack edge; next cycle starts a full edge later
        wb_req_o <= '0;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the threshold interrupt enable block
`include "threshold_irq_enable_cfg_params.svh"
`default_nettype none
module tb_top;
    import threshold_irq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;         // 50 MHz clock
    logic        rst_i = 1'b1;         // synchronous reset
    wb_req_t     wb_req;               // bus request from host
    logic        wb_ack;               // bus answer
    logic [31:0] wb_dat;               // read data
    thr_set_t    thr = '{default: 10'h1f4}; // every threshold at 500
    sample_set_t smp = '0;             // samples and strobes
    logic        irq;                  // interrupt level
    int          err_count = 0;        // mismatches
    int          compares = 0;         // comparisons made

    always #10 clk_i = ~clk_i;

    threshold_irq_enable_cfg dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_ack_o(wb_ack),
                                    .wb_dat_o(wb_dat), .thr_i(thr), .smp_i(smp), .irq_o(irq));
    host_model host_u (.clk_i(clk_i), .wb_req_o(wb_req), .wb_ack_i(wb_ack), .wb_dat_i(wb_dat));

    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run, also reached when a wait runs out
    task automatic wrap_up();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // single comparison point, four-state exact
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // bus wrappers; a lost ack ends the run
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] q;
        bit          ok;
        host_u.xfer(1'b1, a, s, d, q, ok);
        if (!ok) begin
            err_count++;
            wrap_up();
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bit ok;
        host_u.xfer(1'b0, a, 4'hf, 32'h0, q, ok);
        if (!ok) begin
            err_count++;
            wrap_up();
        end
    endtask

    // one strobe on all three inputs, then wait past the status latency
    task automatic send(input logic [9:0] v22, input logic [9:0] v23, input logic [9:0] vs);
        @(posedge clk_i);
        smp <= '{supply_sample: vs, supply_valid: 1'b1, switch_input_twentytwo: v22, twentytwo_valid: 1'b1,
                 switch_input_twentythree: v23, twentythree_valid: 1'b1};
        @(posedge clk_i);
        smp.supply_valid      <= 1'b0;
        smp.twentytwo_valid   <= 1'b0;
        smp.twentythree_valid <= 1'b0;
        // two spare cycles beyond the two-edge latency keep the read clear of it
        repeat (3) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // reset values, lane writes, upper bits and an unmapped address
    task automatic t_regs();
        logic [31:0] q;
        rd(`EN_CFG_ADDR, q);   chk("en reset", q, 32'h0);
        rd(`THR89_ADDR, q);    chk("thr reset", q, 32'h0);
        rd(8'hfc, q);          chk("unmapped", q, 32'h0);
        wr(`EN_CFG_ADDR, 32'hffffffff);
        rd(`EN_CFG_ADDR, q);   chk("en all", q, 32'h00ffffff);
        wr(`EN_CFG_ADDR, 32'h0, 4'h2);
        rd(`EN_CFG_ADDR, q);   chk("en lane", q, 32'h00ff00ff);
        wr(`THR89_ADDR, 32'hffffffff);
        rd(`THR89_ADDR, q);    chk("thr all", q, 32'h000fffff);
        wr(`THR89_ADDR, {12'h0, 10'h1f4, 10'h1f4});
        wr(`EN_CFG_ADDR, 32'h0);
        $display("test regs done");
    endtask

    // every selector code on input 22 against level a, mask and irq level
    task automatic t_codes();
        logic [31:0] q;
        for (int c = 0; c < 4; c++) begin
            wr(`EN_CFG_ADDR, c);
            wr(`IRQ_MASK_ADDR, 32'h1);
            wr(`IRQ_STAT_ADDR, 32'hfff);
            send(10'h3e8, 10'h0, 10'h0);
            rd(`IRQ_STAT_ADDR, q); chk("rise", q, c & 1);
            chk("irq rise", {31'h0, irq}, c & 1);
            wr(`IRQ_STAT_ADDR, 32'hfff);
            @(posedge clk_i);
            chk("irq clr", {31'h0, irq}, 32'h0);
            send(10'h0, 10'h0, 10'h0);
            rd(`IRQ_STAT_ADDR, q); chk("fall", q, (c >> 1) & 1);
            wr(`IRQ_MASK_ADDR, 32'h0);
            @(posedge clk_i);
            chk("irq masked", {31'h0, irq}, 32'h0);
            wr(`IRQ_STAT_ADDR, 32'hfff);
            // equal to the threshold counts as below: no crossing
            send(10'h1f4, 10'h0, 10'h0);
            rd(`IRQ_STAT_ADDR, q); chk("equal", q, 32'h0);
        end
        $display("test codes done");
    endtask

    // each pair alone enabled: only its own status bit may set
    task automatic t_map();
        logic [31:0] q;
        wr(`IRQ_MASK_ADDR, 32'hfff);
        for (int i = 0; i < 12; i++) begin
            wr(`EN_CFG_ADDR, 32'h3 << (2 * i));
            wr(`IRQ_STAT_ADDR, 32'hfff);
            send(10'h3e8, 10'h3e8, 10'h3e8);
            rd(`IRQ_STAT_ADDR, q); chk("map", q, 32'h1 << i);
            chk("irq map", {31'h0, irq}, 32'h1);
            rd(`RELATION_ADDR, q); chk("relation", q, 32'hfff);
            send(10'h0, 10'h0, 10'h0);
            wr(`IRQ_STAT_ADDR, 32'hfff);
        end
        // threshold eight low and nine high tell the two pairs apart
        wr(`THR89_ADDR, {12'h0, 10'h384, 10'h064});
        wr(`EN_CFG_ADDR, 32'h5000);
        wr(`IRQ_STAT_ADDR, 32'hfff);
        send(10'h0, 10'h1f4, 10'h0);
        rd(`IRQ_STAT_ADDR, q); chk("thr eight", q, 32'h040);
        send(10'h0, 10'h3e8, 10'h0);
        rd(`IRQ_STAT_ADDR, q); chk("thr nine", q, 32'h0c0);
        $display("test map done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence with an overall time limit
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        // first strobe only primes the relations
        send(10'h0, 10'h0, 10'h0);
        t_codes();
        t_map();
        wrap_up();
    end

    initial begin
        #1ms;
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
